/* atr_pkg.sv */
// Package with task-file offsets, field positions, timing and carrier types
package atr_pkg;
	localparam int CLK_MHZ = 100;
	localparam int BUSY_SET_NS = 400;
	localparam int BUSY_SET_CYC = (BUSY_SET_NS * CLK_MHZ) / 1000;
	localparam int WRITE_BUSY_US = 5;
	localparam int WRITE_BUSY_CYC = WRITE_BUSY_US * CLK_MHZ;
	localparam int RESET_BUSY_S = 31;
	localparam longint RESET_BUSY_CYC = longint'(RESET_BUSY_S) * 64'd100000000;
	localparam logic [2:0] OFS_FEATURE = 3'h1;
	localparam logic [2:0] OFS_COUNT = 3'h2;
	localparam logic [2:0] OFS_SECTOR = 3'h3;
	localparam logic [2:0] OFS_TRACK_LO = 3'h4;
	localparam logic [2:0] OFS_TRACK_HI = 3'h5;
	localparam logic [2:0] OFS_UNIT_HEAD = 3'h6;
	localparam logic [2:0] OFS_CMD_STAT = 3'h7;
	localparam logic [2:0] OFS_CTRL = 3'h6;
	localparam logic [2:0] OFS_HEAD_RB = 3'h7;
	localparam int POS_LBA_MODE = 6;
	localparam int POS_UNIT_SEL = 4;
	localparam int POS_SOFT_RESET = 2;
	localparam int POS_INT_EN_N = 1;
	localparam int POS_BUSY = 7;
	localparam int POS_READY = 6;
	localparam int POS_WFAULT = 5;
	localparam int POS_SEEK = 4;
	localparam int POS_XFER_REQ = 3;
	localparam int POS_CORRECTED_ERROR_FLAG = 2;
	localparam int POS_INDEX = 1;
	localparam int POS_ERR = 0;
	localparam int POS_FLOAT_BIT = 7;
	localparam logic [7:0] RST_UNIT_HEAD = 8'hA0;
	localparam logic [7:0] RST_COUNT = 8'h01;
	localparam logic [7:0] RST_SECTOR = 8'h01;
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [8:0] FULL_COUNT = 9'h100;

	typedef struct packed {
		logic [7:0] count;
		logic [7:0] sector;
		logic [7:0] trackLo;
		logic [7:0] trackHi;
		logic [3:0] head;
	} atr_addr_s;

	typedef struct packed {
		logic ready;
		logic writeFault;
		logic seekDone;
		logic xferReq;
		logic corrected;
		logic err;
	} atr_cond_s;

	// Commands whose busy must rise within the short command delay
	function automatic logic isFastBusyCmd(input logic [7:0] code);
		logic r;
		r = 1'b0;
		if (code[7:4] == 4'h1 || code[7:4] == 4'h7)
			r = 1'b1;
		if (code == 8'h20 || code == 8'h21 || code == 8'h22 || code == 8'h23)
			r = 1'b1;
		if (code == 8'h40 || code == 8'h41 || code == 8'h91 || code == 8'h90)
			r = 1'b1;
		if (code == 8'hE4 || code == 8'hEC)
			r = 1'b1;
		return r;
	endfunction
endpackage

/* atr_busy_timer.sv */
// Busy timer: raises busy after a request and holds it until released or until the requested span runs out
`timescale 1ns/100ps
`default_nettype none
module atr_busy_timer #(
	parameter int CNT_W = 32
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic clkEn,
	input wire logic start,
	input wire logic [CNT_W-1:0] holdCycles,
	input wire logic release_,
	output logic busy
);
	logic [CNT_W-1:0] remain;

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			busy <= 1'b0;
			remain <= '0;
		end
		else if (clkEn)
		begin
			if (start)
			begin
				busy <= 1'b1;
				remain <= holdCycles;
			end
			else if (release_ || (busy && remain == '0))
			begin
				busy <= 1'b0;
			end
			else if (busy)
			begin
				remain <= remain - 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

/* atr_task_file.sv */
// Task-file register block of an AT-attachment solid-state drive
// How it works
// - A transfer count of zero means 256 sectors, else that many.
// - At completion the count is zero on success, else sectors left.
// - In LBA mode start sector holds address bits 0-7, updated at completion.
// - Low track register holds cylinder low or address bits 8-15.
// - High track register holds cylinder high or address bits 16-23.
// - Unit/head bit 6 picks CHS (0) or LBA (1) addressing.
// - Respond as unit zero when bit 4 is 0; a 1 is ignored.
// - Low four unit/head bits give head or address bits 24-27.
// - Reading primary status while interrupt pending acknowledges it.
// - Other status bits are valid once busy clears; host ignores them meanwhile.
// - During busy, any command-block read except offset 0 returns status.
// - Busy rises within 400 ns of reset or soft reset, may last 31 s.
// - Busy rises within 400 ns of listed non-write commands.
// - Busy rises within 5 us after a host write data block.
// - On error ready, fault, seek flags freeze until status is read.
// - Writing a command code at offset 7 starts execution.
// - Alternate status mirrors status and never acknowledges interrupts.
// - Soft-reset bit 2 holds the device in reset until cleared.
// - Interrupt pin driven only if selected and enable-low bit 1 is 0.
// - Head readback gives inverted head in bits 5-2, bit 0 low if unit zero.
// - A new command aborts one in progress and starts itself.
`timescale 1ns/100ps
`default_nettype none
module atr_task_file #(
	parameter longint RESET_BUSY_CYCLES = atr_pkg::RESET_BUSY_CYC
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic clkEn,
	input wire logic hostResetPin_n,
	input wire logic command_block_select_n,
	input wire logic control_block_select_n,
	input wire logic [2:0] regAddr,
	input wire logic readStrobe_n,
	input wire logic writeStrobe_n,
	input wire logic [7:0] dataIn,
	output logic [7:0] dataOut,
	output logic [7:0] dataOutEn_n,
	output logic intrqOut,
	output logic intrqOutEn_n,
	output logic [7:0] featureSelect,
	output logic [7:0] cmdCode,
	output logic cmdStart,
	output logic cmdAbort,
	output logic lbaMode,
	output logic [8:0] requestedSectors,
	output atr_pkg::atr_addr_s startAddr,
	output logic deviceInReset,
	output logic busy_flag,
	input wire logic dataBlockDone,
	input wire logic cmdDone,
	input wire logic cmdFailed,
	input wire logic raiseIrq,
	input wire logic resetDone,
	input wire atr_pkg::atr_addr_s doneAddr,
	input wire atr_pkg::atr_cond_s liveCond
);
	import atr_pkg::*;

	logic [2:0] syncCs1, syncCs3, syncRd, syncWr, syncRstPin;
	logic [2:0] addrMeta, addrSync;
	logic [7:0] dataMeta, dataSync;
	logic cs1, cs3, rdEdge, wrEdge, rstPinRise;
	logic [7:0] count, sector, trackLo, trackHi, unitHead, ctrl;
	logic irqPending, frozen;
	atr_cond_s heldCond, shownCond;
	logic [7:0] statusByte, next_dataOut, next_dataOutEn_n;
	logic srstPrev, resetStart, cmdStartBusy, writeBusy, timerStart;
	logic [31:0] holdCycles;
	logic unitZero, softReset, hostRst;

	// Pin inputs: two flops, then an edge-detect stage on the settled copy
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			syncCs1 <= 3'h7;
			syncCs3 <= 3'h7;
			syncRd <= 3'h7;
			syncWr <= 3'h7;
			syncRstPin <= 3'h7;
			addrMeta <= 3'h0;
			addrSync <= 3'h0;
			dataMeta <= 8'h00;
			dataSync <= 8'h00;
		end
		else if (clkEn)
		begin
			syncCs1 <= {syncCs1[1:0], command_block_select_n};
			syncCs3 <= {syncCs3[1:0], control_block_select_n};
			syncRd <= {syncRd[1:0], readStrobe_n};
			syncWr <= {syncWr[1:0], writeStrobe_n};
			syncRstPin <= {syncRstPin[1:0], hostResetPin_n};
			addrMeta <= regAddr;
			addrSync <= addrMeta;
			dataMeta <= dataIn;
			dataSync <= dataMeta;
		end
	end

	assign cs1 = !syncCs1[1];
	assign cs3 = !syncCs3[1];
	assign rdEdge = syncRd[2] && !syncRd[1];
	assign wrEdge = syncWr[2] && !syncWr[1];
	assign rstPinRise = !syncRstPin[2] && syncRstPin[1];
	assign hostRst = !syncRstPin[1];
	assign softReset = ctrl[POS_SOFT_RESET];
	assign unitZero = !unitHead[POS_UNIT_SEL];
	assign lbaMode = unitHead[POS_LBA_MODE];
	assign deviceInReset = hostRst || softReset;

	// Control block register
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst || hostRst)
			ctrl <= RST_CTRL;
		else if (clkEn && wrEdge && cs3 && !cs1 && addrSync == OFS_CTRL)
			ctrl <= dataSync;
	end

	// Command block registers; host writes refused while busy
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst || deviceInReset)
		begin
			featureSelect <= 8'h00;
			count <= RST_COUNT;
			sector <= RST_SECTOR;
			trackLo <= 8'h00;
			trackHi <= 8'h00;
			unitHead <= RST_UNIT_HEAD;
		end
		else if (clkEn)
		begin
			if (cmdDone)
			begin
				count <= doneAddr.count;
				sector <= doneAddr.sector;
				trackLo <= doneAddr.trackLo;
				trackHi <= doneAddr.trackHi;
				unitHead[3:0] <= doneAddr.head;
			end
			else if (wrEdge && cs1 && !cs3 && !busy_flag)
			begin
				unique case (addrSync)
					OFS_FEATURE: featureSelect <= dataSync;
					OFS_COUNT: count <= dataSync;
					OFS_SECTOR: sector <= dataSync;
					OFS_TRACK_LO: trackLo <= dataSync;
					OFS_TRACK_HI: trackHi <= dataSync;
					OFS_UNIT_HEAD: unitHead <= dataSync;
					default: ;
				endcase
			end
		end
	end

	assign requestedSectors = (count == 8'h00) ? FULL_COUNT : {1'b0, count};

	always_comb
	begin
		startAddr.count = count;
		startAddr.sector = sector;
		startAddr.trackLo = trackLo;
		startAddr.trackHi = trackHi;
		startAddr.head = unitHead[3:0];
	end

	// Command issue: a new code aborts whatever runs
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst || deviceInReset)
		begin
			cmdCode <= 8'h00;
			cmdStart <= 1'b0;
			cmdAbort <= 1'b0;
		end
		else if (clkEn)
		begin
			cmdStart <= 1'b0;
			cmdAbort <= 1'b0;
			if (wrEdge && cs1 && !cs3 && addrSync == OFS_CMD_STAT && unitZero)
			begin
				cmdCode <= dataSync;
				cmdStart <= 1'b1;
				cmdAbort <= busy_flag;
			end
		end
	end

	// Busy sources
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			srstPrev <= 1'b0;
		else if (clkEn)
			srstPrev <= softReset;
	end

	assign resetStart = rstPinRise || (softReset && !srstPrev);
	assign cmdStartBusy = cmdStart && isFastBusyCmd(cmdCode);
	assign writeBusy = dataBlockDone;
	assign timerStart = resetStart || cmdStartBusy || writeBusy || (cmdStart && !isFastBusyCmd(cmdCode));
	assign holdCycles = resetStart ? 32'(RESET_BUSY_CYCLES) : 32'hFFFFFFFF;

	atr_busy_timer #(
		.CNT_W(32)
	) busyTimer (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.clkEn(clkEn),
		.start(timerStart),
		.holdCycles(holdCycles),
		.release_((resetDone && !deviceInReset) || cmdDone),
		.busy(busy_flag)
	);

	// Interrupt pending: set wins over an acknowledge in the same cycle
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst || deviceInReset)
			irqPending <= 1'b0;
		else if (clkEn)
		begin
			if (raiseIrq)
				irqPending <= 1'b1;
			else if (rdEdge && cs1 && !cs3 && addrSync == OFS_CMD_STAT)
				irqPending <= 1'b0;
		end
	end

	// Error freeze of ready, fault and seek flags
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst || deviceInReset)
		begin
			frozen <= 1'b0;
			heldCond <= '0;
		end
		else if (clkEn)
		begin
			if (cmdDone && cmdFailed)
			begin
				frozen <= 1'b1;
				heldCond <= liveCond;
			end
			else if (rdEdge && cs1 && !cs3 && addrSync == OFS_CMD_STAT)
				frozen <= 1'b0;
			if (cmdDone)
				heldCond.err <= cmdFailed;
		end
	end

	always_comb
	begin
		shownCond = liveCond;
		shownCond.err = heldCond.err;
		if (frozen)
		begin
			shownCond.ready = heldCond.ready;
			shownCond.writeFault = heldCond.writeFault;
			shownCond.seekDone = heldCond.seekDone;
		end
		if (deviceInReset)
			shownCond.ready = 1'b0;
		statusByte = 8'h00;
		statusByte[POS_BUSY] = busy_flag;
		statusByte[POS_READY] = shownCond.ready && !busy_flag;
		statusByte[POS_WFAULT] = shownCond.writeFault && !busy_flag;
		statusByte[POS_SEEK] = shownCond.seekDone && !busy_flag;
		statusByte[POS_XFER_REQ] = shownCond.xferReq && !busy_flag;
		statusByte[POS_CORRECTED_ERROR_FLAG] = shownCond.corrected && !busy_flag;
		statusByte[POS_INDEX] = 1'b0;
		statusByte[POS_ERR] = shownCond.err && !busy_flag;
	end

	// Read data path
	always_comb
	begin
		next_dataOut = 8'h00;
		next_dataOutEn_n = 8'hFF;
		if (!syncRd[1] && cs1 && !cs3 && addrSync != 3'h0 && unitZero)
		begin
			next_dataOutEn_n = 8'h00;
			if (busy_flag)
				next_dataOut = statusByte;
			else
			begin
				unique case (addrSync)
					OFS_COUNT: next_dataOut = count;
					OFS_SECTOR: next_dataOut = sector;
					OFS_TRACK_LO: next_dataOut = trackLo;
					OFS_TRACK_HI: next_dataOut = trackHi;
					OFS_UNIT_HEAD: next_dataOut = unitHead;
					OFS_CMD_STAT: next_dataOut = statusByte;
					default: next_dataOut = 8'h00;
				endcase
			end
		end
		else if (!syncRd[1] && cs3 && !cs1 && addrSync == OFS_CTRL)
		begin
			next_dataOutEn_n = 8'h00;
			next_dataOut = statusByte;
		end
		else if (!syncRd[1] && cs3 && !cs1 && addrSync == OFS_HEAD_RB)
		begin
			next_dataOutEn_n = 8'h00;
			next_dataOutEn_n[POS_FLOAT_BIT] = 1'b1;
			next_dataOut = {2'b01, ~unitHead[3:0], 1'b1, !unitZero};
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			dataOut <= 8'h00;
			dataOutEn_n <= 8'hFF;
		end
		// Snapshot at the start of a read, held while the strobe stays low,
		// so an acknowledge or freeze release cannot change the byte mid-read
		else if (clkEn && (syncRd[1] || rdEdge))
		begin
			dataOut <= next_dataOut;
			dataOutEn_n <= next_dataOutEn_n;
		end
	end

	// Interrupt pin: tristated unless selected and enabled
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			intrqOut <= 1'b0;
			intrqOutEn_n <= 1'b1;
		end
		else if (clkEn)
		begin
			intrqOut <= irqPending;
			intrqOutEn_n <= !(unitZero && !ctrl[POS_INT_EN_N]);
		end
	end
endmodule
`default_nettype wire

/* atr_task_file_chk.sv */
// Port checker for the task-file block
`timescale 1ns/100ps
`default_nettype none
module atr_task_file_chk #(
	parameter longint RESET_BUSY_CYCLES = 50
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic hostResetPin_n,
	input wire logic [7:0] dataOut,
	input wire logic [7:0] dataOutEn_n,
	input wire logic cmdStart,
	input wire logic cmdAbort,
	input wire logic cmdDone,
	input wire logic [8:0] requestedSectors,
	input wire atr_pkg::atr_addr_s startAddr,
	input wire logic deviceInReset,
	input wire logic busy_flag
);
	import atr_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	chk_cmd_busy: assert property (cmdStart |-> ##[1:40] busy_flag)
		else $error("busy late after command");
	chk_abort_busy: assert property (cmdStart |-> cmdAbort == $past(busy_flag))
		else $error("abort does not match busy");
	chk_count_full: assert property (requestedSectors ==
		(startAddr.count == 8'h00 ? 9'h100 : {1'b0, startAddr.count}))
		else $error("sector count wrong");
	chk_pin_busy: assert property ($rose(hostResetPin_n) |-> ##[1:40] busy_flag)
		else $error("busy late after pin reset");
	chk_soft_busy: assert property
		($rose(deviceInReset) && hostResetPin_n |-> ##[0:40] busy_flag)
		else $error("busy late after soft reset");
	chk_busy_status: assert property
		($fell(dataOutEn_n[7]) && $past(busy_flag) |-> dataOut[7])
		else $error("busy read not status");
	chk_readback_ones: assert property (dataOutEn_n == 8'h80 |-> dataOut[6] && dataOut[1])
		else $error("readback unused bits low");
	chk_done_idle: assert property
		(cmdDone && !cmdStart && !deviceInReset |-> ##[1:2] !busy_flag)
		else $error("busy stays after done");
endmodule
bind atr_task_file atr_task_file_chk #(.RESET_BUSY_CYCLES(RESET_BUSY_CYCLES)) i_atr_task_file_chk (
	.clk_sys, .sys_rst, .hostResetPin_n, .dataOut, .dataOutEn_n, .cmdStart, .cmdAbort,
	.cmdDone, .requestedSectors, .startAddr, .deviceInReset, .busy_flag);
`default_nettype wire

/* atr_host_model.sv */
// Host adapter model driving the task-file bus pins
`timescale 1ns/100ps
`default_nettype none
module atr_host_model (
	input wire logic clk_sys,
	input wire logic [7:0] dataBus,
	input wire logic floatBit,
	output logic command_block_select_n,
	output logic control_block_select_n,
	output logic [2:0] regAddr,
	output logic readStrobe_n,
	output logic writeStrobe_n,
	output logic [7:0] hostData,
	output logic rdDone,
	output logic [8:0] rdData
);
	initial
	begin
		{command_block_select_n, control_block_select_n, readStrobe_n, writeStrobe_n} = 4'hF;
		{regAddr, hostData, rdDone, rdData} = '0;
	end
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic sel(input logic ctl, input logic [2:0] a);
		step(1);
		command_block_select_n = ctl;
		control_block_select_n = !ctl;
		regAddr = a;
	endtask
	task automatic wr(input logic ctl, input logic [2:0] a, input logic [7:0] d);
		sel(ctl, a);
		hostData = d;
		step(4);
		writeStrobe_n = 1'b0;
		step(5);
		writeStrobe_n = 1'b1;
		step(5);
		// Released bus shows the inverse of the last byte
		hostData = ~d;
		{command_block_select_n, control_block_select_n} = 2'h3;
	endtask
	task automatic rd(input logic ctl, input logic [2:0] a);
		sel(ctl, a);
		step(4);
		readStrobe_n = 1'b0;
		step(6);
		rdData = {floatBit, dataBus};
		rdDone = 1'b1;
		step(1);
		rdDone = 1'b0;
		readStrobe_n = 1'b1;
		step(5);
		{command_block_select_n, control_block_select_n} = 2'h3;
	endtask
endmodule
`default_nettype wire

/* tb.sv */
// Self-checking testbench for the task-file block
`timescale 1ns/100ps
`default_nettype none
module tb;
	import atr_pkg::*;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic hostResetPin_n = 1'b1;
	logic dataBlockDone = 1'b0;
	logic cmdDone = 1'b0;
	logic cmdFailed = 1'b0;
	logic raiseIrq = 1'b0;
	logic resetDone = 1'b0;
	atr_addr_s doneAddr = '0;
	atr_cond_s liveCond = 6'b101000;
	wire logic csCmd_n, csCtl_n, rd_n, wr_n;
	wire logic [2:0] addr;
	wire logic [7:0] hData;
	logic [7:0] dataOut, dataOutEn_n, featSel, lastCode, r[2:6];
	logic intrqOut, intrqOutEn_n, lbaMode, deviceInReset, busy_flag;
	logic [8:0] requestedSectors, m;
	logic [8:0] expQ[$];
	logic [8:0] mskQ[$];
	logic [7:0] fast[12] = '{8'h10, 8'h20, 8'h21, 8'h22, 8'h23, 8'h40, 8'h41, 8'h70, 8'h91,
		8'h90, 8'hE4, 8'hEC};
	int err_total = 0;
	int comparisons = 0;
	int cyc = 0;
	int n;
	always #5 clk_sys = ~clk_sys;
	atr_host_model i_atr_host_model (.clk_sys(clk_sys), .dataBus(dataOut),
		.floatBit(dataOutEn_n[7]), .command_block_select_n(csCmd_n),
		.control_block_select_n(csCtl_n), .regAddr(addr), .readStrobe_n(rd_n),
		.writeStrobe_n(wr_n), .hostData(hData), .rdDone(), .rdData());
	atr_task_file #(.RESET_BUSY_CYCLES(50)) i_atr_task_file (.clk_sys(clk_sys),
		.sys_rst(sys_rst), .clkEn(1'b1), .hostResetPin_n(hostResetPin_n),
		.command_block_select_n(csCmd_n), .control_block_select_n(csCtl_n), .regAddr(addr),
		.readStrobe_n(rd_n), .writeStrobe_n(wr_n), .dataIn(hData), .dataOut(dataOut),
		.dataOutEn_n(dataOutEn_n), .intrqOut(intrqOut), .intrqOutEn_n(intrqOutEn_n),
		.featureSelect(featSel), .cmdCode(lastCode), .cmdStart(), .cmdAbort(), .lbaMode(lbaMode),
		.requestedSectors(requestedSectors), .startAddr(), .deviceInReset(deviceInReset),
		.busy_flag(busy_flag), .dataBlockDone(dataBlockDone), .cmdDone(cmdDone),
		.cmdFailed(cmdFailed), .raiseIrq(raiseIrq), .resetDone(resetDone),
		.doneAddr(doneAddr), .liveCond(liveCond));
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic check(input string nm, input logic [8:0] seen, input logic [8:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic rdx(input logic ctl, input logic [2:0] a, input logic [8:0] k, v);
		mskQ.push_back(k);
		expQ.push_back(v);
		i_atr_host_model.rd(ctl, a);
	endtask
	task automatic wrx(input logic ctl, input logic [2:0] a, input logic [7:0] d);
		i_atr_host_model.wr(ctl, a, d);
	endtask
	task automatic step(input int k);
		i_atr_host_model.step(k);
	endtask
	always @(posedge clk_sys)
		if (i_atr_host_model.rdDone === 1'b1 && mskQ.size() > 0)
		begin
			m = mskQ.pop_front();
			check("read", i_atr_host_model.rdData & m, expQ.pop_front() & m);
		end
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			err_total++;
			test_done();
		end
	end
	initial
	begin
		n = $urandom(32'h2FD7);
		step(12);
		sys_rst = 1'b0;
		step(2);
		for (int i = 0; i < 4; i++)
		begin
			r[2] = (i == 0) ? 8'h00 : 8'($urandom);
			r[3] = 8'($urandom_range(1, 63));
			r[4] = 8'($urandom);
			r[5] = 8'($urandom);
			r[6] = {1'b1, i[0], 2'b10, 4'($urandom)};
			for (int a = 2; a < 7; a++)
				wrx(0, 3'(a), r[a]);
			check("sectors", requestedSectors, r[2] == 0 ? 9'h100 : {1'b0, r[2]});
			check("lba", 9'(lbaMode), 9'(i[0]));
			for (int a = 2; a < 7; a++)
				rdx(0, 3'(a), 9'h1FF, {1'b0, r[a]});
			rdx(1, 3'h7, 9'h17F, {3'b101, ~r[6][3:0], 2'b10});
		end
		wrx(0, 3'h1, 8'h5A);
		wrx(0, 3'h7, 8'h20);
		check("busy", 9'(busy_flag), 9'h001);
		check("code", {1'b0, lastCode}, 9'h020);
		rdx(0, 3'h2, 9'h080, 9'h080);
		rdx(1, 3'h6, 9'h080, 9'h080);
		wrx(0, 3'h1, 8'hA5);
		check("feature", {1'b0, featSel}, 9'h05A);
		wrx(0, 3'h7, 8'h21);
		doneAddr = {$urandom, 4'($urandom)};
		{cmdDone, cmdFailed} = 2'h3;
		step(1);
		{cmdDone, cmdFailed} = 2'h0;
		liveCond.ready = 1'b0;
		step(3);
		check("idle", 9'(busy_flag), 9'h000);
		rdx(1, 3'h6, 9'h0C1, 9'h041);
		rdx(0, 3'h7, 9'h0C1, 9'h041);
		rdx(0, 3'h7, 9'h040, 9'h000);
		liveCond.ready = 1'b1;
		for (int a = 2; a < 6; a++)
			rdx(0, 3'(a), 9'h0FF, {1'b0, doneAddr[51 - 8 * a -: 8]});
		rdx(0, 3'h6, 9'h00F, {5'h00, doneAddr.head});
		doneAddr.count = 8'h00;
		foreach (fast[k])
		begin
			wrx(0, 3'h7, fast[k]);
			check("cmd busy", 9'(busy_flag), 9'h001);
			cmdDone = 1'b1;
			step(1);
			cmdDone = 1'b0;
			step(2);
		end
		rdx(0, 3'h2, 9'h0FF, 9'h000);
		dataBlockDone = 1'b1;
		step(1);
		dataBlockDone = 1'b0;
		for (n = 0; n < 500 && busy_flag !== 1'b1; n++)
			step(1);
		check("block busy", 9'(busy_flag), 9'h001);
		cmdDone = 1'b1;
		step(1);
		cmdDone = 1'b0;
		for (int e = 0; e < 2; e++)
		begin
			wrx(1, 3'h6, {6'h00, e[0], 1'b0});
			raiseIrq = 1'b1;
			step(1);
			raiseIrq = 1'b0;
			step(3);
			check("irq", {7'h00, intrqOutEn_n, intrqOut}, {7'h00, e[0], 1'b1});
			rdx(1, 3'h6, 9'h080, 9'h000);
			check("irq kept", 9'(intrqOut), 9'h001);
			rdx(0, 3'h7, 9'h080, 9'h000);
			check("irq ack", 9'(intrqOut), 9'h000);
		end
		wrx(0, 3'h6, 8'hB0);
		wrx(0, 3'h7, 8'h20);
		step(2);
		check("unit one", 9'(busy_flag), 9'h000);
		wrx(0, 3'h6, 8'hA0);
		wrx(1, 3'h6, 8'h04);
		check("soft", {7'h00, deviceInReset, busy_flag}, 9'h003);
		wrx(1, 3'h6, 8'h00);
		resetDone = 1'b1;
		step(1);
		resetDone = 1'b0;
		step(3);
		check("soft end", 9'(busy_flag), 9'h000);
		rdx(0, 3'h2, 9'h0FF, 9'h001);
		hostResetPin_n = 1'b0;
		step(5);
		hostResetPin_n = 1'b1;
		step(8);
		check("pin busy", 9'(busy_flag), 9'h001);
		step(60);
		check("pin end", 9'(busy_flag), 9'h000);
		test_done();
	end
endmodule
`default_nettype wire
